// ==== rtl/rai_consts.svh ====
`ifndef RAI_CONSTS_SVH
`define RAI_CONSTS_SVH
// register byte addresses
`define RAI_ADDR_ALIAS4 8'h7a
`define RAI_ADDR_ALIAS5 8'h7b
`define RAI_ADDR_ALIAS6 8'h7c
`define RAI_ADDR_ALIAS7 8'h7d
`define RAI_ADDR_IRQ_EN 8'hc6
`define RAI_ADDR_IRQ_STAT 8'hc7
// reset values
`define RAI_ALIAS_RESET 8'h00
`define RAI_IRQ_EN_RESET 8'h00
// field positions
`define RAI_BIT_IND_DONE 7
`define RAI_BIT_RX_DET 6
`define RAI_BIT_DOWNSTREAM 5
`define RAI_BIT_GLOBAL 0
// writable mask of the enable register (bits 4..1 reserved, kept as zero)
`define RAI_IRQ_EN_MASK 8'he1
// alias count and first alias index
`define RAI_ALIAS_COUNT 4
`define RAI_ALIAS_FIRST 4
`endif

// ==== rtl/rai_pkg.sv ====
package rai_pkg;
    // register access request from the local control interface
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rai_reg_req_type;
    // incoming i2c address to be remapped
    typedef struct packed {
        logic valid;
        logic [6:0] addr;
    } rai_i2c_req_type;
    // forwarded transaction toward the back channel
    typedef struct packed {
        logic valid;
        logic [6:0] remote_addr;
        logic [1:0] slot;
    } rai_fwd_type;
    // remap lookup states
    typedef enum logic [1:0] {
        RAI_IDLE = 2'b00,
        RAI_LOOK = 2'b01,
        RAI_SEND = 2'b11
    } rai_state_type;
endpackage

// ==== rtl/rai_alias_mem.sv ====
`timescale 1ns/1ps
`include "rai_consts.svh"
// holds alias bytes for both ports, one write port, registered read
module rai_alias_mem #(
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [6:0] wr_data,
    input wire logic [2:0] rd_idx,
    output logic [6:0] rd_data,
    output logic [DEPTH*7-1:0] all_data
);
    // seven-bit fields per entry, bit 0 of the byte is not stored
    logic [6:0] mem_r [DEPTH];
    logic [6:0] mem_nxt [DEPTH];
    logic [6:0] rd_r;
    logic [6:0] rd_nxt;

    // next values for storage and read register
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_nxt[i] = mem_r[i];
        end
        if (wr_en) begin
            mem_nxt[wr_idx] = wr_data;
        end
        rd_nxt = mem_r[rd_idx];
    end

    // register everything
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= 7'h00;
            end
            rd_r <= 7'h00;
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= mem_nxt[i];
            end
            rd_r <= rd_nxt;
        end
    end

    // flat view for parallel matching
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            all_data[i*7 +: 7] = mem_r[i];
        end
    end

    assign rd_data = rd_r;
endmodule // rai_alias_mem

// ==== rtl/rai_remote_alias.sv ====
// Notes on behaviour
// - alias stored in bits 7:1, bit0 reserved
// - matching alias address replaced by target id
// - zero alias disables its entry entirely
// - port select picks port1 or port0 copy
// - aliases at 0x7a..0x7d, rw, reset zero
// - enable bit7 gates indirect-done interrupt
// - enable bit6 gates receiver-detect interrupt
// - detect waits for lock when selected
// - enable bit5 passes downstream interrupts; bit4 reserved
// - remapped transaction sent over back channel
// - enable bit0 drives interrupt output globally
// - status bit0 set when enabled source pending
`timescale 1ns/1ps
`include "rai_consts.svh"
module rai_remote_alias
    import rai_pkg::*;
#(
    parameter int NUM_ALIAS = `RAI_ALIAS_COUNT
) (
    input wire logic sys_clk,
    input wire logic rstn,
    // register access
    input wire rai_reg_req_type reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // configuration and target ids from the rest of the bank
    input wire logic second_port_select,
    input wire logic detect_waits_lock_select,
    input wire logic [NUM_ALIAS*7-1:0] target_id_p0,
    input wire logic [NUM_ALIAS*7-1:0] target_id_p1,
    // event pins (asynchronous levels)
    input wire logic indirect_done,
    input wire logic rx_detect,
    input wire logic rx_lock,
    input wire logic downstream_irq,
    // incoming i2c address
    input wire rai_i2c_req_type i2c_req,
    output logic i2c_busy,
    // forwarded transaction toward the back channel
    output rai_fwd_type fwd,
    output logic irq_out
);
    // reset synchroniser
    logic rst_s1_r;
    logic rst_n_r;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // two-flop synchronisers for event pins
    logic [3:0] ev_s1_r;
    logic [3:0] ev_s2_r;
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ev_s1_r <= 4'h0;
            ev_s2_r <= 4'h0;
        end else begin
            ev_s1_r <= {downstream_irq, rx_lock, rx_detect, indirect_done};
            ev_s2_r <= ev_s1_r;
        end
    end
    logic ind_s;
    logic det_s;
    logic lock_s;
    logic dsi_s;
    assign ind_s = ev_s2_r[0];
    assign det_s = ev_s2_r[1];
    assign lock_s = ev_s2_r[2];
    assign dsi_s = ev_s2_r[3];

    // decode an alias address into its slot, valid flag in bit 2
    function automatic logic [2:0] alias_slot(input logic [7:0] a);
        logic [2:0] s;
        s = 3'h0;
        unique case (a)
            `RAI_ADDR_ALIAS4: s = 3'h4;
            `RAI_ADDR_ALIAS5: s = 3'h5;
            `RAI_ADDR_ALIAS6: s = 3'h6;
            `RAI_ADDR_ALIAS7: s = 3'h7;
            default: s = 3'h0;
        endcase
        return s;
    endfunction

    // alias storage: index = {port, slot}
    logic mem_wr;
    logic [2:0] mem_wr_idx;
    logic [2:0] mem_rd_idx;
    logic [6:0] mem_rd_data;
    logic [NUM_ALIAS*2*7-1:0] mem_all;
    logic [2:0] req_slot;
    assign req_slot = alias_slot(reg_req.addr);
    assign mem_wr = reg_req.wr && req_slot[2];
    assign mem_wr_idx = {second_port_select, req_slot[1:0]};
    assign mem_rd_idx = {second_port_select, req_slot[1:0]};

    rai_alias_mem #(
        .DEPTH(NUM_ALIAS * 2)
    ) u_mem (
        .sys_clk(sys_clk),
        .rst_n(rst_n_r),
        .wr_en(mem_wr),
        .wr_idx(mem_wr_idx),
        .wr_data(reg_req.wdata[7:1]),
        .rd_idx(mem_rd_idx),
        .rd_data(mem_rd_data),
        .all_data(mem_all)
    );

    // interrupt enable register and pending flags
    logic [7:0] irq_en_r;
    logic [7:0] irq_en_nxt;
    logic [7:5] pend_r;
    logic [7:5] pend_nxt;
    logic ind_d_r;
    logic ind_d_nxt;
    logic det_d_r;
    logic det_d_nxt;
    logic irq_r;
    logic irq_nxt;
    logic det_q;
    logic stat_rd;
    logic global_pend;

    assign det_q = det_s && (!detect_waits_lock_select || lock_s);
    assign stat_rd = reg_req.rd && (reg_req.addr == `RAI_ADDR_IRQ_STAT);
    assign global_pend = |(pend_r & irq_en_r[7:5]);

    // next values for enables, pending flags and interrupt output
    always_comb begin
        irq_en_nxt = irq_en_r;
        pend_nxt = pend_r;
        ind_d_nxt = ind_s;
        det_d_nxt = det_q;
        if (reg_req.wr && reg_req.addr == `RAI_ADDR_IRQ_EN) begin
            irq_en_nxt = reg_req.wdata & `RAI_IRQ_EN_MASK;
        end
        // status read clears event flags; a new set wins
        if (stat_rd) begin
            pend_nxt[7:6] = 2'b00;
        end
        if (ind_s && !ind_d_r) begin
            pend_nxt[`RAI_BIT_IND_DONE] = 1'b1;
        end
        if (det_q && !det_d_r) begin
            pend_nxt[`RAI_BIT_RX_DET] = 1'b1;
        end
        pend_nxt[`RAI_BIT_DOWNSTREAM] = dsi_s;
        irq_nxt = irq_en_r[`RAI_BIT_GLOBAL] && global_pend;
    end

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            irq_en_r <= `RAI_IRQ_EN_RESET;
            pend_r <= 3'h0;
            ind_d_r <= 1'b0;
            det_d_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            irq_en_r <= irq_en_nxt;
            pend_r <= pend_nxt;
            ind_d_r <= ind_d_nxt;
            det_d_r <= det_d_nxt;
            irq_r <= irq_nxt;
        end
    end

    // read path: alias data comes from the memory one cycle later
    logic rd_alias_r;
    logic rd_alias_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic rvalid_d_r;
    logic rvalid_d_nxt;
    logic [7:0] rdata_hold_r;
    logic [7:0] rdata_hold_nxt;

    // stage one: registers other than aliases
    always_comb begin
        rd_alias_nxt = reg_req.rd && req_slot[2];
        rvalid_nxt = reg_req.rd;
        rdata_hold_nxt = 8'h00;
        if (reg_req.rd && reg_req.addr == `RAI_ADDR_IRQ_EN) begin
            rdata_hold_nxt = irq_en_r;
        end else if (stat_rd) begin
            rdata_hold_nxt = {pend_r & irq_en_r[7:5], 4'h0, global_pend};
        end
    end

    // stage two: merge alias byte, bit 0 reads zero
    always_comb begin
        rvalid_d_nxt = rvalid_r;
        rdata_nxt = rd_alias_r ? {mem_rd_data, 1'b0} : rdata_hold_r;
    end

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rd_alias_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_hold_r <= 8'h00;
            rvalid_d_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            rd_alias_r <= rd_alias_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_hold_r <= rdata_hold_nxt;
            rvalid_d_r <= rvalid_d_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // remap engine
    rai_state_type state_r;
    rai_state_type state_nxt;
    logic [6:0] addr_r;
    logic [6:0] addr_nxt;
    logic hit_r;
    logic hit_nxt;
    logic [1:0] slot_r;
    logic [1:0] slot_nxt;
    rai_fwd_type fwd_r;
    rai_fwd_type fwd_nxt;
    logic busy_r;
    logic busy_nxt;

    // parallel compare against the selected port's aliases
    logic m_hit;
    logic [1:0] m_slot;
    always_comb begin
        m_hit = 1'b0;
        m_slot = 2'h0;
        for (int i = NUM_ALIAS - 1; i >= 0; i--) begin
            if (mem_all[({second_port_select, 2'(i)}) * 7 +: 7] == addr_r &&
                mem_all[({second_port_select, 2'(i)}) * 7 +: 7] != 7'h00) begin
                m_hit = 1'b1;
                m_slot = 2'(i);
            end
        end
    end

    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        hit_nxt = hit_r;
        slot_nxt = slot_r;
        fwd_nxt = '0;
        busy_nxt = busy_r;
        unique case (state_r)
            RAI_IDLE: begin
                if (i2c_req.valid) begin
                    addr_nxt = i2c_req.addr;
                    busy_nxt = 1'b1;
                    state_nxt = RAI_LOOK;
                end
            end
            RAI_LOOK: begin
                hit_nxt = m_hit;
                slot_nxt = m_slot;
                state_nxt = RAI_SEND;
            end
            RAI_SEND: begin
                if (hit_r) begin
                    fwd_nxt.valid = 1'b1;
                    fwd_nxt.slot = slot_r;
                    fwd_nxt.remote_addr = second_port_select ?
                        target_id_p1[slot_r*7 +: 7] : target_id_p0[slot_r*7 +: 7];
                end
                busy_nxt = 1'b0;
                state_nxt = RAI_IDLE;
            end
            default: state_nxt = RAI_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= RAI_IDLE;
            addr_r <= 7'h00;
            hit_r <= 1'b0;
            slot_r <= 2'h0;
            fwd_r <= '0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            hit_r <= hit_nxt;
            slot_r <= slot_nxt;
            fwd_r <= fwd_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_d_r;
    assign fwd = fwd_r;
    assign i2c_busy = busy_r;
    assign irq_out = irq_r;
endmodule // rai_remote_alias

// ==== bench/rai_remote_alias_props.sv ====
`timescale 1ns/1ps
// watches register answers, remap lookups and the interrupt output
module rai_remote_alias_props
    import rai_pkg::*;
#(
    parameter int NUM_ALIAS = 4
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire rai_reg_req_type reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic second_port_select,
    input wire logic [NUM_ALIAS*7-1:0] target_id_p0,
    input wire logic [NUM_ALIAS*7-1:0] target_id_p1,
    input wire rai_i2c_req_type i2c_req,
    input wire logic i2c_busy,
    input wire rai_fwd_type fwd,
    input wire logic irq_out
);
    logic en0_r; // shadow of the global enable bit
    logic en0_nxt;
    logic [6:0] tid; // target id of the forwarded slot
    // follow writes to the enable register
    always_comb begin
        en0_nxt = en0_r;
        if (reg_req.wr && reg_req.addr == 8'hc6) begin
            en0_nxt = reg_req.wdata[0];
        end
    end
    // register the shadow
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            en0_r <= 1'b0;
        end else begin
            en0_r <= en0_nxt;
        end
    end
    assign tid = second_port_select ? target_id_p1[fwd.slot*7 +: 7] : target_id_p0[fwd.slot*7 +: 7];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    chk_read_latency: assert property (reg_req.rd |-> ##2 reg_rvalid)
        else $error("read answer late or missing");
    chk_stray_answer: assert property (reg_rvalid |-> $past(reg_req.rd, 2))
        else $error("read answer without a read");
    chk_alias_bit_zero: assert property (reg_rvalid && $past(reg_req.addr, 2) inside {[8'h7a:8'h7d]} |-> !reg_rdata[0])
        else $error("alias bit 0 not zero");
    chk_enable_reserved: assert property (reg_rvalid && $past(reg_req.addr, 2) == 8'hc6 |-> reg_rdata[4:1] == 4'h0)
        else $error("reserved enable bits not zero");
    chk_irq_global: assert property (irq_out |-> en0_r || $past(en0_r))
        else $error("interrupt output without global enable");
    chk_fwd_target: assert property (fwd.valid |-> fwd.remote_addr == tid)
        else $error("forwarded address is not the target id");
    chk_take_lookup: assert property (i2c_req.valid && !i2c_busy |=> i2c_busy)
        else $error("lookup not started");
    chk_lookup_ends: assert property ($rose(i2c_busy) |-> ##[1:3] !i2c_busy)
        else $error("lookup did not finish");
endmodule // rai_remote_alias_props
bind rai_remote_alias rai_remote_alias_props #(.NUM_ALIAS(NUM_ALIAS)) chk_u (.sys_clk(sys_clk), .rstn(rstn),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .second_port_select(second_port_select),
    .target_id_p0(target_id_p0), .target_id_p1(target_id_p1), .i2c_req(i2c_req), .i2c_busy(i2c_busy),
    .fwd(fwd), .irq_out(irq_out));

// ==== bench/rai_remote_target.sv ====
`timescale 1ns/1ps
// far end: remote targets behind the back channel, logs each forwarded access
module rai_remote_target
    import rai_pkg::*;
(
    input wire logic sys_clk,
    input wire rai_fwd_type fwd,
    output logic [6:0] last_addr,
    output logic [1:0] last_slot,
    output int hits
);
    logic [6:0] addr_r = 7'h00; // last remapped address seen
    logic [1:0] slot_r = 2'h0; // slot of that access
    int hits_r = 0; // forwarded accesses so far
    always @(posedge sys_clk) begin
        if (fwd.valid === 1'b1) begin
            addr_r <= fwd.remote_addr;
            slot_r <= fwd.slot;
            hits_r <= hits_r + 1;
        end
    end
    assign last_addr = addr_r;
    assign last_slot = slot_r;
    assign hits = hits_r;
endmodule // rai_remote_target

// ==== bench/remote_alias_and_irq_enable_test.sv ====
`timescale 1ns/1ps
module remote_alias_and_irq_enable_test;
    import rai_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    rai_reg_req_type reg_req = '0;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic second_port_select = 1'b0;
    logic detect_waits_lock_select = 1'b0;
    logic [27:0] target_id_p0 = {7'h14, 7'h13, 7'h12, 7'h11};
    logic [27:0] target_id_p1 = {7'h24, 7'h23, 7'h22, 7'h21};
    logic indirect_done = 1'b0;
    logic rx_detect = 1'b0;
    logic rx_lock = 1'b0;
    logic downstream_irq = 1'b0;
    rai_i2c_req_type i2c_req = '0;
    logic i2c_busy;
    rai_fwd_type fwd;
    logic irq_out;
    logic [6:0] last_addr;
    logic [1:0] last_slot;
    int hits;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    always #4 sys_clk = ~sys_clk;
    rai_remote_alias #(.NUM_ALIAS(4)) dut_u (.sys_clk(sys_clk), .rstn(rstn), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .second_port_select(second_port_select),
        .detect_waits_lock_select(detect_waits_lock_select), .target_id_p0(target_id_p0),
        .target_id_p1(target_id_p1), .indirect_done(indirect_done), .rx_detect(rx_detect), .rx_lock(rx_lock),
        .downstream_irq(downstream_irq), .i2c_req(i2c_req), .i2c_busy(i2c_busy), .fwd(fwd), .irq_out(irq_out));
    rai_remote_target far_u (.sys_clk(sys_clk), .fwd(fwd), .last_addr(last_addr), .last_slot(last_slot),
        .hits(hits));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one write strobe, held for one edge
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk);
        reg_req = '0;
    endtask
    // one read strobe, then wait a bounded time for the answer
    task automatic expect_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        @(negedge sys_clk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge sys_clk);
        reg_req = '0;
        d = 8'hxx;
        repeat (4) begin
            @(posedge sys_clk);
            #1;
            if (reg_rvalid === 1'b1) begin
                d = reg_rdata;
            end
        end
        check(what, exp, d);
    endtask
    // present one address and count what reaches the far end
    task automatic lookup(input logic [6:0] a, input int exp_hit, input logic [6:0] exp_addr,
            input logic [1:0] exp_slot);
        int h0;
        h0 = hits;
        @(negedge sys_clk);
        i2c_req = '{valid: 1'b1, addr: a};
        @(negedge sys_clk);
        i2c_req = '0;
        repeat (5) @(negedge sys_clk);
        check("forward count", 8'(exp_hit), 8'(hits - h0));
        if (exp_hit != 0) begin
            check("remote address", {1'b0, exp_addr}, {1'b0, last_addr});
            check("remote slot", {6'h00, exp_slot}, {6'h00, last_slot});
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // cut a hang short
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (8) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (4) @(negedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            expect_reg("alias reset", 8'h7a + 8'(i), 8'h00);
            reg_write(8'h7a + 8'(i), {7'h30 + 7'(i), 1'b1});
        end
        expect_reg("enable reset", 8'hc6, 8'h00);
        expect_reg("unmapped", 8'h80, 8'h00);
        for (int i = 0; i < 4; i++) begin
            expect_reg("alias port0", 8'h7a + 8'(i), {7'h30 + 7'(i), 1'b0});
        end
        @(negedge sys_clk);
        second_port_select = 1'b1;
        expect_reg("alias port1", 8'h7a, 8'h00);
        reg_write(8'h7a, 8'ha0);
        expect_reg("alias port1", 8'h7a, 8'ha0);
        lookup(7'h50, 1, 7'h21, 2'h0);
        lookup(7'h31, 0, 7'h00, 2'h0);
        lookup(7'h00, 0, 7'h00, 2'h0);
        @(negedge sys_clk);
        second_port_select = 1'b0;
        expect_reg("alias port0", 8'h7a, 8'h60);
        lookup(7'h32, 1, 7'h13, 2'h2);
        reg_write(8'h7d, 8'h00);
        lookup(7'h33, 0, 7'h00, 2'h0);
        reg_write(8'hc6, 8'hff);
        expect_reg("enable", 8'hc6, 8'he1);
        @(negedge sys_clk);
        indirect_done = 1'b1;
        repeat (6) @(negedge sys_clk);
        check("irq out", 8'h01, {7'h00, irq_out});
        expect_reg("status", 8'hc7, 8'h81);
        expect_reg("status", 8'hc7, 8'h00);
        @(negedge sys_clk);
        indirect_done = 1'b0;
        detect_waits_lock_select = 1'b1;
        rx_detect = 1'b1;
        repeat (6) @(negedge sys_clk);
        expect_reg("status", 8'hc7, 8'h00);
        @(negedge sys_clk);
        rx_lock = 1'b1;
        repeat (6) @(negedge sys_clk);
        // the indirect-done flag was cleared by the earlier status read
        expect_reg("status", 8'hc7, 8'h41);
        @(negedge sys_clk);
        downstream_irq = 1'b1;
        repeat (6) @(negedge sys_clk);
        // detect flag cleared by the previous read, downstream is a level
        expect_reg("status", 8'hc7, 8'h21);
        reg_write(8'hc6, 8'h01);
        expect_reg("status", 8'hc7, 8'h00);
        check("irq out", 8'h00, {7'h00, irq_out});
        // without the lock wait, detect alone raises the flag
        @(negedge sys_clk);
        rx_detect = 1'b0;
        rx_lock = 1'b0;
        detect_waits_lock_select = 1'b0;
        repeat (6) @(negedge sys_clk);
        reg_write(8'hc6, 8'h41);
        rx_detect = 1'b1;
        repeat (6) @(negedge sys_clk);
        check("irq out", 8'h01, {7'h00, irq_out});
        expect_reg("status", 8'hc7, 8'h41);
        complete_run();
    end
endmodule // remote_alias_and_irq_enable_test
